// File: inc/tcp_timer16_map.vh
`ifndef TCP_TIMER16_MAP_VH
`define TCP_TIMER16_MAP_VH

// Register indices on the plain register port.
`define TCP_ADDR_W 4
`define TCP_ADDR_MODE 4'h0
`define TCP_ADDR_PRESCALER 4'h1
`define TCP_ADDR_OUT_CTRL 4'h2
`define TCP_ADDR_CAP_CTRL 4'h3
`define TCP_ADDR_CMP_A 4'h4
`define TCP_ADDR_CMP_B 4'h5
`define TCP_ADDR_COUNT 4'h6
`define TCP_ADDR_STATUS 4'h7

// timer_mode_control fields.
`define TCP_MODE_RUN_LSB 2
`define TCP_MODE_RUN_MSB 3
`define TCP_RUN_STOP 2'h0
`define TCP_RUN_CLEAR_ON_EDGE 2'h1
`define TCP_RUN_FREE 2'h2
`define TCP_RUN_CLEAR_ON_MATCH 2'h3

// prescaler_mode_control fields.
`define TCP_PRE_CLK_LSB 0
`define TCP_PRE_CLK_MSB 1
`define TCP_PRE_EDGE_A_LSB 4
`define TCP_PRE_EDGE_A_MSB 5
`define TCP_PRE_EDGE_B_LSB 6
`define TCP_PRE_EDGE_B_MSB 7
`define TCP_CLK_SYS 2'h0
`define TCP_CLK_DIV4 2'h1
`define TCP_CLK_DIV16 2'h2
`define TCP_CLK_EDGE_B 2'h3

// Valid edge encodings.
`define TCP_EDGE_FALL 2'h0
`define TCP_EDGE_RISE 2'h1
`define TCP_EDGE_NONE 2'h2
`define TCP_EDGE_BOTH 2'h3

// Output control fields.
`define TCP_OUT_ENABLE 0
`define TCP_OUT_INV_A 1
`define TCP_OUT_INV_B 2
`define TCP_OUT_ONESHOT 3
`define TCP_OUT_SOFT_TRIG 4

// Capture control fields.
`define TCP_CAP_A_ON_B 0
`define TCP_CAP_B_ON_A 1

// Status fields.
`define TCP_STAT_BUSY 0
`define TCP_STAT_LEVEL 1

// Widths and reset values.
`define TCP_DATA_W 16
`define TCP_DIV_W 4
`define TCP_DIV4_MASK 4'h3
`define TCP_DIV16_MASK 4'hF
`define TCP_RST_WORD 16'h0000
`define TCP_RST_EDGE 2'h0

`endif

// File: logic/tcp_edge_detect.v
`timescale 1ns/1ps
`default_nettype none

module tcp_edge_detect
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Control
  input wire i_enable,
  input wire [1:0] i_edge_sel,
  // Pin
  input wire i_pin,
  // Result
  output wire o_edge
);

`include "tcp_timer16_map.vh"

  reg pin_prev;
  reg armed;
  wire rise;
  wire fall;

  // ----------------------------------------------------------------
  // Pin history
  // ----------------------------------------------------------------
  // The history holds low from reset until the first enable, so a pin
  // pulled high shows a rising edge at once. Once armed it keeps tracking
  // the pin while stopped, so a re-enable with the pin high shows none.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_prev <= 1'b0;
      armed <= 1'b0;
    end
    else
    begin
      if (i_enable)
        armed <= 1'b1;
      if (i_enable || armed)
        pin_prev <= i_pin;
    end
  end

  assign rise = i_pin & ~pin_prev;
  assign fall = ~i_pin & pin_prev;

  assign o_edge = i_enable & (((i_edge_sel == `TCP_EDGE_RISE) & rise) |
                              ((i_edge_sel == `TCP_EDGE_FALL) & fall) |
                              ((i_edge_sel == `TCP_EDGE_BOTH) & (rise | fall)));

endmodule

`default_nettype wire

// File: logic/tcp_timer16.v
// Notes on behaviour
// - High pin after reset gives rising edge
// - Shared pin: output or B edge, not both
// - Pulse period A+1, active B+1 counts
// - Input A edge still triggers one-shot
// - Nonzero run mode starts counting at once
// - Triggers during one-shot pulse ignored
// - Start may deviate one count period
// - Compare values kept across stop
// - Matches raise match A and B requests
`timescale 1ns/1ps
`default_nettype none

module tcp_timer16
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Register port
  input wire [3:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_write,
  input wire i_reg_read,
  output reg [15:0] o_reg_rdata,
  // Pins
  input wire i_capture_input_a,
  input wire i_capture_input_b,
  output reg o_timer_output_pin,
  output wire o_timer_output_pin_oe,
  // Match requests
  output reg o_match_a_irq,
  output reg o_match_b_irq
);

`include "tcp_timer16_map.vh"

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [1:0] run_mode;
  reg [1:0] count_clk_sel;
  reg [1:0] edge_sel_a;
  reg [1:0] edge_sel_b;
  reg pin_output_enable;
  reg invert_on_match_a_enable;
  reg invert_on_match_b_enable;
  reg oneshot_enable;
  reg capture_a_on_b;
  reg capture_b_on_a;
  reg [15:0] compare_capture_a;
  reg [15:0] compare_capture_b;
  reg [15:0] count_register;
  reg [3:0] div_count;
  reg oneshot_busy;

  reg [15:0] next_count;
  reg next_out;
  reg next_busy;
  reg [15:0] next_rdata;

  wire running;
  wire edge_a;
  wire edge_b;
  wire edge_b_enable;
  wire count_tick;
  wire match_a;
  wire match_b;
  wire wr_mode;
  wire wr_pre;
  wire wr_out;
  wire wr_cap;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire oneshot_soft_trigger;
  wire oneshot_trigger;
  wire oneshot_start;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_mode = i_reg_write & (i_reg_addr == `TCP_ADDR_MODE);
  assign wr_pre = i_reg_write & (i_reg_addr == `TCP_ADDR_PRESCALER);
  assign wr_out = i_reg_write & (i_reg_addr == `TCP_ADDR_OUT_CTRL);
  assign wr_cap = i_reg_write & (i_reg_addr == `TCP_ADDR_CAP_CTRL);
  assign wr_cmp_a = i_reg_write & (i_reg_addr == `TCP_ADDR_CMP_A);
  assign wr_cmp_b = i_reg_write & (i_reg_addr == `TCP_ADDR_CMP_B);

  // The soft trigger bit is a strobe; it is never stored.
  assign oneshot_soft_trigger = wr_out & i_reg_wdata[`TCP_OUT_SOFT_TRIG];

  // Any nonzero run mode starts the counter on the next edge.
  assign running = (run_mode != `TCP_RUN_STOP);

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_mode <= `TCP_RUN_STOP;
      count_clk_sel <= `TCP_CLK_SYS;
      edge_sel_a <= `TCP_RST_EDGE;
      edge_sel_b <= `TCP_RST_EDGE;
      pin_output_enable <= 1'b0;
      invert_on_match_a_enable <= 1'b0;
      invert_on_match_b_enable <= 1'b0;
      oneshot_enable <= 1'b0;
      capture_a_on_b <= 1'b0;
      capture_b_on_a <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        run_mode <= i_reg_wdata[`TCP_MODE_RUN_MSB:`TCP_MODE_RUN_LSB];
      // Edge selects are expected to change only while stopped; a change
      // while running may produce a spurious edge.
      if (wr_pre)
      begin
        count_clk_sel <= i_reg_wdata[`TCP_PRE_CLK_MSB:`TCP_PRE_CLK_LSB];
        edge_sel_a <= i_reg_wdata[`TCP_PRE_EDGE_A_MSB:`TCP_PRE_EDGE_A_LSB];
        edge_sel_b <= i_reg_wdata[`TCP_PRE_EDGE_B_MSB:`TCP_PRE_EDGE_B_LSB];
      end
      if (wr_out)
      begin
        pin_output_enable <= i_reg_wdata[`TCP_OUT_ENABLE];
        invert_on_match_a_enable <= i_reg_wdata[`TCP_OUT_INV_A];
        invert_on_match_b_enable <= i_reg_wdata[`TCP_OUT_INV_B];
        oneshot_enable <= i_reg_wdata[`TCP_OUT_ONESHOT];
      end
      if (wr_cap)
      begin
        capture_a_on_b <= i_reg_wdata[`TCP_CAP_A_ON_B];
        capture_b_on_a <= i_reg_wdata[`TCP_CAP_B_ON_A];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input edge detection
  // ----------------------------------------------------------------
  // Input B shares its pin with the timer output, so its edges are
  // blocked whenever the pin is driven.
  assign edge_b_enable = running & ~pin_output_enable;
  assign o_timer_output_pin_oe = pin_output_enable;

  tcp_edge_detect u_edge_a
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(running),
    .i_edge_sel(edge_sel_a),
    .i_pin(i_capture_input_a),
    .o_edge(edge_a)
  );

  tcp_edge_detect u_edge_b
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_enable(edge_b_enable),
    .i_edge_sel(edge_sel_b),
    .i_pin(i_capture_input_b),
    .o_edge(edge_b)
  );

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  // The divider runs free and is not restarted by a start, so the first
  // match after start may land up to one count period early.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_count <= 4'h0;
    else
      div_count <= div_count + 4'h1;
  end

  assign count_tick = running &
    (((count_clk_sel == `TCP_CLK_SYS)) |
     ((count_clk_sel == `TCP_CLK_DIV4) &
      ((div_count & `TCP_DIV4_MASK) == `TCP_DIV4_MASK)) |
     ((count_clk_sel == `TCP_CLK_DIV16) & (div_count == `TCP_DIV16_MASK)) |
     ((count_clk_sel == `TCP_CLK_EDGE_B) & edge_b));

  // Compare matches are taken on the count clock only.
  assign match_a = count_tick & (count_register == compare_capture_a);
  assign match_b = count_tick & (count_register == compare_capture_b);

  // ----------------------------------------------------------------
  // One-shot trigger
  // ----------------------------------------------------------------
  // An input A edge triggers a one-shot even when software triggering is
  // in use, so the input A pin must be kept quiet in that case.
  assign oneshot_trigger = oneshot_enable & running &
                           (oneshot_soft_trigger | edge_a);
  // A trigger during a pulse is dropped and does not restart the count.
  assign oneshot_start = oneshot_trigger & ~oneshot_busy;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @*
  begin
    next_count = count_register;
    if (!running)
      next_count = `TCP_RST_WORD;
    else if (oneshot_start)
      next_count = `TCP_RST_WORD;
    else if ((run_mode == `TCP_RUN_CLEAR_ON_EDGE) && edge_a && !oneshot_enable)
      next_count = `TCP_RST_WORD;
    else if (count_tick)
    begin
      // Clearing on match A gives a period of compare A plus one counts.
      if ((run_mode == `TCP_RUN_CLEAR_ON_MATCH) && match_a)
        next_count = `TCP_RST_WORD;
      else
        next_count = count_register + 16'h0001;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_register <= `TCP_RST_WORD;
    else
      count_register <= next_count;
  end

  // ----------------------------------------------------------------
  // Capture and compare registers
  // ----------------------------------------------------------------
  // A capture beats a software write in the same cycle. Both registers
  // keep their contents across a stop; software need not reload them.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      compare_capture_a <= `TCP_RST_WORD;
      compare_capture_b <= `TCP_RST_WORD;
    end
    else
    begin
      if (capture_a_on_b && edge_b)
        compare_capture_a <= count_register;
      else if (wr_cmp_a)
        compare_capture_a <= i_reg_wdata;
      if (capture_b_on_a && edge_a)
        compare_capture_b <= count_register;
      else if (wr_cmp_b)
        compare_capture_b <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Timer output and one-shot state
  // ----------------------------------------------------------------
  always @*
  begin
    next_out = o_timer_output_pin;
    next_busy = oneshot_busy;
    if (!running)
    begin
      next_out = 1'b0;
      next_busy = 1'b0;
    end
    else if (oneshot_enable)
    begin
      if (oneshot_start)
      begin
        next_busy = 1'b1;
        next_out = 1'b0;
      end
      else if (oneshot_busy && match_a)
      begin
        next_busy = 1'b0;
        next_out = 1'b0;
      end
      else if (oneshot_busy && match_b)
        next_out = 1'b1;
    end
    else
    begin
      // Active from the match on A to the match on B: B plus one counts
      // out of a period of A plus one. The level starts low and B comes
      // first, so the active span is the low one.
      if ((match_a && invert_on_match_a_enable) ^
          (match_b && invert_on_match_b_enable))
        next_out = ~o_timer_output_pin;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_timer_output_pin <= 1'b0;
      oneshot_busy <= 1'b0;
    end
    else
    begin
      o_timer_output_pin <= next_out;
      oneshot_busy <= next_busy;
    end
  end

  // ----------------------------------------------------------------
  // Match requests
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_match_a_irq <= 1'b0;
      o_match_b_irq <= 1'b0;
    end
    else
    begin
      o_match_a_irq <= match_a;
      o_match_b_irq <= match_b;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @*
  begin
    next_rdata = `TCP_RST_WORD;
    case (i_reg_addr)
      `TCP_ADDR_MODE:
        next_rdata[`TCP_MODE_RUN_MSB:`TCP_MODE_RUN_LSB] = run_mode;
      `TCP_ADDR_PRESCALER:
      begin
        next_rdata[`TCP_PRE_CLK_MSB:`TCP_PRE_CLK_LSB] = count_clk_sel;
        next_rdata[`TCP_PRE_EDGE_A_MSB:`TCP_PRE_EDGE_A_LSB] = edge_sel_a;
        next_rdata[`TCP_PRE_EDGE_B_MSB:`TCP_PRE_EDGE_B_LSB] = edge_sel_b;
      end
      `TCP_ADDR_OUT_CTRL:
      begin
        next_rdata[`TCP_OUT_ENABLE] = pin_output_enable;
        next_rdata[`TCP_OUT_INV_A] = invert_on_match_a_enable;
        next_rdata[`TCP_OUT_INV_B] = invert_on_match_b_enable;
        next_rdata[`TCP_OUT_ONESHOT] = oneshot_enable;
      end
      `TCP_ADDR_CAP_CTRL:
      begin
        next_rdata[`TCP_CAP_A_ON_B] = capture_a_on_b;
        next_rdata[`TCP_CAP_B_ON_A] = capture_b_on_a;
      end
      `TCP_ADDR_CMP_A:
        next_rdata = compare_capture_a;
      `TCP_ADDR_CMP_B:
        next_rdata = compare_capture_b;
      `TCP_ADDR_COUNT:
        next_rdata = count_register;
      `TCP_ADDR_STATUS:
      begin
        next_rdata[`TCP_STAT_BUSY] = oneshot_busy;
        next_rdata[`TCP_STAT_LEVEL] = o_timer_output_pin;
      end
      default:
        next_rdata = `TCP_RST_WORD;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= `TCP_RST_WORD;
    else if (i_reg_read)
      o_reg_rdata <= next_rdata;
    else
      o_reg_rdata <= `TCP_RST_WORD;
  end

endmodule

`default_nettype wire

// File: verif/tcp_pin_src.sv
`timescale 1ns/1ps
`default_nettype none

module tcp_pin_src
(
  // Clock
  input wire logic i_clk_sys,
  // Requests from the bench
  input wire logic i_level_a,
  input wire logic i_pulse_a,
  // Shared pin drive from the timer
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  // Pins seen by the timer
  output logic o_capture_input_a,
  output logic o_capture_input_b
);
  logic [2:0] hold = 3'h0;
  logic b_src = 1'b0;

  // A trigger lasts four clocks so that it spans more than two count clocks.
  always @(posedge i_clk_sys)
  begin
    if (i_pulse_a)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
    b_src <= ~b_src;
  end

  // Between requests the trigger line keeps its base level.
  assign o_capture_input_a = i_level_a | (hold != 3'h0);
  // A released shared pin toggles, so a stale level can never pass for a drive.
  assign o_capture_input_b = i_pin_oe ? i_pin_out : b_src;
endmodule
`default_nettype wire

// File: verif/tcp_timer16_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcp_timer16_map.vh"

module tcp_timer16_sva
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [15:0] o_reg_rdata,
  // Pins and requests
  input wire logic i_capture_input_a,
  input wire logic i_capture_input_b,
  input wire logic o_timer_output_pin,
  input wire logic o_timer_output_pin_oe,
  input wire logic o_match_a_irq,
  input wire logic o_match_b_irq
);
  // ----------------------------------------
  // Shadow of the control bits
  // ----------------------------------------
  logic [1:0] run_mode;
  logic one_r;
  logic inv_a_r;
  logic inv_b_r;
  wire mode_wr = i_reg_write && i_reg_addr == `TCP_ADDR_MODE;
  wire out_wr = i_reg_write && i_reg_addr == `TCP_ADDR_OUT_CTRL;
  wire programmable_pulse_output = run_mode == `TCP_RUN_CLEAR_ON_MATCH && !one_r;
  wire ppg_a = programmable_pulse_output && inv_a_r;
  wire ppg_b = programmable_pulse_output && inv_b_r;
  wire plain_run = run_mode != `TCP_RUN_STOP && !one_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_mode <= 2'h0;
      one_r <= 1'b0;
      inv_a_r <= 1'b0;
      inv_b_r <= 1'b0;
    end
    else
    begin
      if (mode_wr)
        run_mode <= i_reg_wdata[3:2];
      if (out_wr)
      begin
        one_r <= i_reg_wdata[`TCP_OUT_ONESHOT];
        inv_a_r <= i_reg_wdata[`TCP_OUT_INV_A];
        inv_b_r <= i_reg_wdata[`TCP_OUT_INV_B];
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_moved;
    $changed(o_timer_output_pin);
  endsequence
  sequence s_cause;
    o_match_a_irq || o_match_b_irq;
  endsequence

  AST_RDATA_IDLE: assert property (!$past(i_reg_read) |-> o_reg_rdata == 16'h0000)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (i_reg_read && i_reg_addr[3] |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_OE_FOLLOW: assert property (out_wr |=> o_timer_output_pin_oe == $past(i_reg_wdata[0]))
    else $error("pin enable not as written");
  AST_IRQ_A_ONE: assert property (o_match_a_irq |=> !o_match_a_irq)
    else $error("match a request too long");
  AST_IRQ_B_ONE: assert property (o_match_b_irq |=> !o_match_b_irq)
    else $error("match b request too long");
  AST_STOP_QUIET: assert property (run_mode == 2'h0 && $past(run_mode) == 2'h0 && $past(run_mode, 2) == 2'h0 |-> !o_match_a_irq && !o_match_b_irq)
    else $error("match while stopped");
  AST_TOGGLE_CAUSE: assert property (plain_run && $past(plain_run) ##0 s_moved |-> s_cause)
    else $error("output moved without match");
  AST_PPG_A: assert property ($past(ppg_a) && o_match_a_irq |-> s_moved)
    else $error("no toggle on match a");
  AST_PPG_B: assert property ($past(ppg_b) && o_match_b_irq |-> s_moved)
    else $error("no toggle on match b");
endmodule

bind tcp_timer16 tcp_timer16_sva chk_u
(
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .o_reg_rdata(o_reg_rdata), .i_capture_input_a(i_capture_input_a),
  .i_capture_input_b(i_capture_input_b), .o_timer_output_pin(o_timer_output_pin),
  .o_timer_output_pin_oe(o_timer_output_pin_oe), .o_match_a_irq(o_match_a_irq),
  .o_match_b_irq(o_match_b_irq)
);
`default_nettype wire

// File: verif/tcp_timer16_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcp_timer16_map.vh"

module tcp_timer16_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic level_a = 1'b1;
  logic pulse_a = 1'b0;
  wire [15:0] reg_rdata;
  wire pin_a;
  wire pin_b;
  wire pin_out;
  wire pin_oe;
  wire irq_a;
  wire irq_b;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int k;
  int t_a;
  int t_b;
  logic lv_a;
  logic lv_b;
  logic [15:0] rv;
  logic [15:0] c0;

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  tcp_timer16 dut_u
  (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
    .i_capture_input_a(pin_a), .i_capture_input_b(pin_b), .o_timer_output_pin(pin_out),
    .o_timer_output_pin_oe(pin_oe), .o_match_a_irq(irq_a), .o_match_b_irq(irq_b)
  );
  tcp_pin_src src_u
  (
    .i_clk_sys(clk_sys), .i_level_a(level_a), .i_pulse_a(pulse_a), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_capture_input_a(pin_a), .o_capture_input_b(pin_b)
  );

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic end_sim;
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  // Callers leave at least two cycles between pulses, which this wait cannot miss.
  task automatic wait_irq(input logic sel_b, output int t, output logic lv);
    int n;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk_sys);
      #1;
      if ((sel_b ? irq_b : irq_a) === 1'b1)
        break;
    end
    chk({15'h0000, n < 400}, 16'h0001);
    t = cyc;
    lv = pin_out;
    @(posedge clk_sys);
  endtask

  task automatic ppg_gap(input int b);
    wait_irq(1'b0, t_a, lv_a);
    wait_irq(1'b1, t_b, lv_b);
    chk(16'(t_b - t_a), 16'(b + 1));
    chk({15'h0000, lv_a ^ lv_b}, 16'h0001);
    wait_irq(1'b0, t_b, lv_b);
    chk(16'(t_b - t_a), 16'h0005);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`TCP_ADDR_MODE, rv);
    chk(rv, 16'h0000);
    wr(4'h9, 16'hFFFF);
    rd(4'h9, rv);
    chk(rv, 16'h0000);
    chk({15'h0000, pin_oe}, 16'h0000);
    // The trigger pin has been high since reset, so the first start sees a rise.
    wr(`TCP_ADDR_PRESCALER, 16'h0010);
    wr(`TCP_ADDR_CMP_A, 16'h000F);
    wr(`TCP_ADDR_CMP_B, 16'h0008);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0009);
    wr(`TCP_ADDR_MODE, 16'h0008);
    repeat (3) @(posedge clk_sys);
    rd(`TCP_ADDR_STATUS, rv);
    chk(rv & 16'h0001, 16'h0001);
    wait_irq(1'b1, t_b, lv_b);
    chk({15'h0000, lv_b}, 16'h0001);
    wait_irq(1'b0, t_a, lv_a);
    chk(16'(t_a - t_b), 16'h0007);
    chk({15'h0000, lv_a}, 16'h0000);
    wr(`TCP_ADDR_MODE, 16'h0000);
    wr(`TCP_ADDR_MODE, 16'h0008);
    repeat (3) @(posedge clk_sys);
    rd(`TCP_ADDR_STATUS, rv);
    chk(rv & 16'h0001, 16'h0000);
    level_a <= 1'b0;
    repeat (20) @(posedge clk_sys);
    pulse_a <= 1'b1;
    @(posedge clk_sys);
    pulse_a <= 1'b0;
    wait_irq(1'b1, t_b, lv_b);
    pulse_a <= 1'b1;
    @(posedge clk_sys);
    pulse_a <= 1'b0;
    wait_irq(1'b0, t_a, lv_a);
    chk(16'(t_a - t_b), 16'h0007);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0019);
    wait_irq(1'b1, t_b, lv_b);
    chk({15'h0000, lv_b}, 16'h0001);
    wait_irq(1'b0, t_a, lv_a);
    chk(16'(t_a - t_b), 16'h0007);
    wr(`TCP_ADDR_MODE, 16'h0000);
    wr(`TCP_ADDR_PRESCALER, 16'h0000);
    wr(`TCP_ADDR_CMP_A, 16'h0004);
    wr(`TCP_ADDR_CMP_B, 16'h0001);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0007);
    wr(`TCP_ADDR_MODE, 16'h000C);
    ppg_gap(1);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0003);
    wr(`TCP_ADDR_CMP_B, 16'h0002);
    @(posedge clk_sys);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0007);
    ppg_gap(2);
    for (k = 0; k < 3; k++)
    begin
      wr(`TCP_ADDR_MODE, 16'h0000);
      wr(`TCP_ADDR_PRESCALER, 16'(k));
      wr(`TCP_ADDR_MODE, 16'h0008);
      rd(`TCP_ADDR_COUNT, c0);
      repeat (14) @(posedge clk_sys);
      rd(`TCP_ADDR_COUNT, rv);
      chk(rv - c0, 16'h0010 >> (2 * k));
    end
    // Clear the running count on an input A rise, with compare B capturing the count.
    wr(`TCP_ADDR_MODE, 16'h0000);
    wr(`TCP_ADDR_PRESCALER, 16'h0010);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0001);
    chk({15'h0000, pin_oe}, 16'h0001);
    wr(`TCP_ADDR_CAP_CTRL, 16'h0002);
    wr(`TCP_ADDR_MODE, 16'h0004);
    repeat (10) @(posedge clk_sys);
    pulse_a <= 1'b1;
    @(posedge clk_sys);
    pulse_a <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(`TCP_ADDR_CMP_B, rv);
    chk(rv, 16'h000C);
    rd(`TCP_ADDR_COUNT, rv);
    chk(rv, 16'h0003);
    // With the shared pin released, its falling edges become the count clock.
    wr(`TCP_ADDR_MODE, 16'h0000);
    wr(`TCP_ADDR_OUT_CTRL, 16'h0000);
    wr(`TCP_ADDR_PRESCALER, 16'h0003);
    wr(`TCP_ADDR_MODE, 16'h0008);
    rd(`TCP_ADDR_COUNT, c0);
    repeat (14) @(posedge clk_sys);
    rd(`TCP_ADDR_COUNT, rv);
    chk(rv - c0, 16'h0008);
    wr(`TCP_ADDR_MODE, 16'h0000);
    rd(`TCP_ADDR_COUNT, rv);
    chk(rv, 16'h0000);
    end_sim();
  end

  initial
  begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
